/* File: rcso_sys_ctrl.sv */
`timescale 1ns/1ns
`include "rcso_map.svh"
module rcso_sys_ctrl #(
  parameter logic [31:0] WDOG_SHORT_CYC = `RCSO_WDOG_SHORT,
  parameter logic [31:0] WDOG_LONG_CYC = `RCSO_WDOG_LONG
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input rcso_pkg::rcso_req_t cpuReq,
  input rcso_pkg::rcso_req_t dbgReq,
  input wire logic porDetect,
  input wire logic resetPin_n,
  input wire logic lowSupply,
  input wire logic brownoutResetEnable,
  input wire logic brownoutStopEnable,
  input wire logic stopModeActive,
  input wire logic wdogTimeout,
  input wire logic stopExec,
  input wire logic bgndExec,
  input wire logic debugModeEnable,
  input wire logic clkGenResetReq,
  output logic [7:0] cpuRdData,
  output logic [7:0] dbgRdData,
  output rcso_pkg::rcso_wdog_t wdogCtrl,
  output logic sysResetReq
);
  import rcso_pkg::*;

  logic [2:0] porSync, pinSync, lowSync;
  logic porStable_r, pinLow_r, lowStable_r;
  logic [7:0] cause_r, causeNxt;
  rcso_srcs_t pend_r, newReq;
  rcso_srcs_t causeSrc;
  logic released_r;
  logic [2:0] opt_r;
  logic optWritten_r;
  logic [7:0] optRead;
  logic [7:0] cpuRdNxt, dbgRdNxt;
  logic wdogKick;
  logic optWrite;
  logic dbgForce;
  logic brownTrip;

  // read value of one register index; shared by cpu and debug ports
  function automatic logic [7:0] rd_mux(input logic [1:0] a, input logic [7:0] st,
                                        input logic [7:0] op);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `RCSO_ADDR_STATUS: v = st;
      `RCSO_ADDR_FORCE: v = `RCSO_FORCE_READ;
      `RCSO_ADDR_OPTIONS: v = op;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_mux

  // three-stage synchronisers; no reset so they keep sampling while reset is held
  always_ff @(posedge ref_clk)
  begin
    porSync <= {porSync[1:0], porDetect};
    pinSync <= {pinSync[1:0], ~resetPin_n};
    lowSync <= {lowSync[1:0], lowSupply};
  end

  // a level is believed once stages two and three agree
  always_ff @(posedge ref_clk)
  begin
    if (porSync[2] == porSync[1])
      porStable_r <= porSync[2];
    if (pinSync[2] == pinSync[1])
      pinLow_r <= pinSync[2];
    if (lowSync[2] == lowSync[1])
      lowStable_r <= lowSync[2];
  end

  // request sources; watchdog gated by its enable, illegal stop by options, illegal background by debug mode
  assign brownTrip = lowStable_r & brownoutResetEnable
                     & (~stopModeActive | brownoutStopEnable);
  assign dbgForce = dbgReq.wr & (dbgReq.addr == `RCSO_ADDR_FORCE)
                    & dbgReq.data[`RCSO_FORCE_BIT];
  assign newReq.brown = brownTrip;
  assign newReq.wdog = wdogTimeout & opt_r[2];
  assign newReq.bad_opcode_flag = (stopExec & ~opt_r[0]) | (bgndExec & ~debugModeEnable);
  assign newReq.clkGen = clkGenResetReq;
  assign newReq.dbg = dbgForce;

  // sources seen at reset: remembered requests plus any still live, so a low supply
  // that only trips while reset is held still leaves its mark
  assign causeSrc = pend_r | newReq;

  // pending requests survive the reset; replaced by the live requests on the first edge after release
  always_ff @(posedge ref_clk)
  begin
    if (rst_n && !released_r)
      pend_r <= newReq;
    else if (rst_n)
      pend_r <= pend_r | newReq;
  end

  // marks the first edge after reset release
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      released_r <= 1'b0;
    else
      released_r <= 1'b1;
  end

  // cause pattern: power-on wins, then low supply, then the rest together unless a debug force clears all
  always_comb
  begin
    causeNxt = 8'h00;
    if (porStable_r)
      causeNxt = `RCSO_CAUSE_POR;
    else if (causeSrc.brown)
    begin
      causeNxt = `RCSO_CAUSE_BROWN;
      causeNxt[`RCSO_ST_POR] = cause_r[`RCSO_ST_POR];
    end
    else if (!causeSrc.dbg)
    begin
      causeNxt[`RCSO_ST_PIN] = pinLow_r;
      causeNxt[`RCSO_ST_WDOG] = causeSrc.wdog;
      causeNxt[`RCSO_ST_BAD_OPCODE_FLAG] = causeSrc.bad_opcode_flag;
      causeNxt[`RCSO_ST_CLKGEN] = causeSrc.clkGen;
    end
  end

  // status is captured while reset is held and frozen afterwards
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      cause_r <= causeNxt;
  end

  // reset request stays up until the reset arrives
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sysResetReq <= 1'b0;
    else if (|newReq)
      sysResetReq <= 1'b1;
  end

  // register writes; cpu writes to the force address fall through unused
  assign wdogKick = cpuReq.wr & (cpuReq.addr == `RCSO_ADDR_STATUS);
  assign optWrite = cpuReq.wr & (cpuReq.addr == `RCSO_ADDR_OPTIONS) & ~optWritten_r;
  assign optRead = {opt_r, 5'h00};

  // write-once options; the first write to the options address is taken and locks out every later one
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opt_r <= `RCSO_OPT_RESET;
      optWritten_r <= 1'b0;
    end
    else if (cpuReq.wr && cpuReq.addr == `RCSO_ADDR_OPTIONS)
    begin
      optWritten_r <= 1'b1;
      if (optWrite)
        opt_r <= cpuReq.data[7:5];
    end
  end

  assign cpuRdNxt = cpuReq.rd ? rd_mux(cpuReq.addr, cause_r, optRead) : 8'h00;
  assign dbgRdNxt = dbgReq.rd ? rd_mux(dbgReq.addr, cause_r, optRead) : 8'h00;

  // read data and watchdog controls, all registered
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpuRdData <= 8'h00;
      dbgRdData <= 8'h00;
      wdogCtrl <= '0;
    end
    else
    begin
      cpuRdData <= cpuRdNxt;
      dbgRdData <= dbgRdNxt;
      wdogCtrl.enable <= opt_r[2];
      wdogCtrl.longSel <= opt_r[1];
      wdogCtrl.restart <= wdogKick;
      wdogCtrl.limit <= opt_r[1] ? WDOG_LONG_CYC : WDOG_SHORT_CYC;
    end
  end

  a_opt_write_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
    optWritten_r && cpuReq.wr && cpuReq.addr == `RCSO_ADDR_OPTIONS |=> opt_r == $past(opt_r))
    else $error("options changed after first write");
  a_opt_first_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !optWritten_r && cpuReq.wr && cpuReq.addr == `RCSO_ADDR_OPTIONS |=> opt_r == $past(cpuReq.data[7:5]))
    else $error("first options write not taken");
  a_force_reads_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpuReq.rd && cpuReq.addr == `RCSO_ADDR_FORCE |=> cpuRdData == 8'h00)
    else $error("force register read not zero");
  a_opt_zero_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpuReq.rd && cpuReq.addr == `RCSO_ADDR_OPTIONS |=> cpuRdData[4:0] == 5'h00 && cpuRdData[7:5] == opt_r)
    else $error("options read wrong");
  a_status_kick: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wdogKick |=> wdogCtrl.restart && cause_r == $past(cause_r))
    else $error("status write did not kick watchdog");
  a_cpu_force_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpuReq.wr && !sysResetReq && newReq == '0 |=> !sysResetReq)
    else $error("cpu write raised a reset request");
  a_dbg_force_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dbgForce |=> sysResetReq && pend_r.dbg)
    else $error("debug force did not request reset");
  a_wdog_blocked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wdogTimeout && !opt_r[2] && !sysResetReq && newReq == '0 |=> !sysResetReq)
    else $error("disabled watchdog raised a reset");
  a_stop_illegal: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stopExec && !opt_r[0] |=> sysResetReq && pend_r.bad_opcode_flag)
    else $error("illegal stop not forced reset");
  // gated by released_r so the edge right after release, still showing reset values, is skipped
  a_wdog_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    released_r |-> wdogCtrl.limit == ($past(opt_r[1]) ? WDOG_LONG_CYC : WDOG_SHORT_CYC))
    else $error("watchdog limit mismatch");

  // enable output follows the options bit one cycle later
  a_wdog_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    released_r |-> wdogCtrl.enable == $past(opt_r[2]))
    else $error("watchdog enable mismatch");

  // long select output follows the options bit one cycle later
  a_wdog_long: assert property (@(posedge ref_clk) disable iff (!rst_n)
    released_r |-> wdogCtrl.longSel == $past(opt_r[1]))
    else $error("watchdog long select mismatch");

  // options hold their defaults until the first edge after release
  a_opt_defaults: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !released_r |-> opt_r == `RCSO_OPT_RESET)
    else $error("options not at defaults after reset");

  // enabled watchdog timeout requests a reset
  a_wdog_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wdogTimeout && opt_r[2] |=> sysResetReq && pend_r.wdog)
    else $error("watchdog timeout did not request reset");

  // background instruction with debug mode off is illegal
  a_background_halt_instr_illegal: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bgndExec && !debugModeEnable |=> sysResetReq && pend_r.bad_opcode_flag)
    else $error("illegal background not forced reset");

  // clock generator request is remembered and raises the reset request
  a_clkgen_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkGenResetReq |=> sysResetReq && pend_r.clkGen)
    else $error("clock generator request lost");

  // brownout trip with the reset enable (and the stop enable when in stop mode) requests a reset
  a_brown_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
    brownTrip |=> sysResetReq && pend_r.brown)
    else $error("brownout trip lost");

  // once raised the request stays until reset arrives
  a_req_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sysResetReq |=> sysResetReq)
    else $error("reset request dropped early");

  // restart pulse only ever follows a status write
  a_restart_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wdogCtrl.restart |-> $past(wdogKick))
    else $error("watchdog restart without status write");

  // debug port also reads the force register as zero
  a_dbg_force_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dbgReq.rd && dbgReq.addr == `RCSO_ADDR_FORCE |=> dbgRdData == 8'h00)
    else $error("debug force read not zero");

  // status is frozen while running; only a reset reloads it
  a_cause_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n)
    released_r |=> cause_r == $past(cause_r))
    else $error("status changed outside reset");
endmodule : rcso_sys_ctrl

/* File: rcso_map.svh */
`ifndef RCSO_MAP_SVH
`define RCSO_MAP_SVH
// register indices on the cpu and debug ports
`define RCSO_ADDR_STATUS 2'h0
`define RCSO_ADDR_FORCE 2'h1
`define RCSO_ADDR_OPTIONS 2'h2
// reset-cause status bit positions
`define RCSO_ST_POR 7
`define RCSO_ST_PIN 6
`define RCSO_ST_WDOG 5
`define RCSO_ST_BAD_OPCODE_FLAG 4
`define RCSO_ST_CLKGEN 2
`define RCSO_ST_BROWN 1
// debug force-reset bit and its read value
`define RCSO_FORCE_BIT 0
`define RCSO_FORCE_READ 8'h00
// options register fields and reset value
`define RCSO_OPT_WDOG_EN 7
`define RCSO_OPT_WDOG_LONG 6
`define RCSO_OPT_STOP_EN 5
`define RCSO_OPT_RESET 3'h6
// cause patterns for power-on and brownout resets
`define RCSO_CAUSE_POR 8'h82
`define RCSO_CAUSE_BROWN 8'h02
// default watchdog lengths in bus cycles
`define RCSO_WDOG_SHORT 32'h0004_0000
`define RCSO_WDOG_LONG 32'h0020_0000
`endif

/* File: rcso_pkg.sv */
package rcso_pkg;
  // one register access from cpu or debug host
  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] data;
  } rcso_req_t;
  // internal reset requests waiting for the reset to happen
  typedef struct packed
  {
    logic brown;
    logic wdog;
    logic bad_opcode_flag;
    logic clkGen;
    logic dbg;
  } rcso_srcs_t;
  // watchdog controls handed to the counter
  typedef struct packed
  {
    logic enable;
    logic longSel;
    logic restart;
    logic [31:0] limit;
  } rcso_wdog_t;
endpackage : rcso_pkg

/* File: rcso_host_model.sv */
`timescale 1ns/1ns
module rcso_host_model (
  input wire logic ref_clk,
  output rcso_pkg::rcso_req_t cpuReq,
  output rcso_pkg::rcso_req_t dbgReq,
  input wire logic [7:0] cpuRdData,
  input wire logic [7:0] dbgRdData
);
  import rcso_pkg::*;
  initial cpuReq = '0;
  initial dbgReq = '0;
  // one byte access held for a single taking edge; data turns over after
  // release so a stale byte never looks valid
  task automatic access(input logic dbg, input logic wr, input logic [1:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    rcso_req_t r;
    r = '{wr: wr, rd: ~wr, addr: a, data: d};
    @(posedge ref_clk);
    if (dbg) dbgReq <= r;
    else cpuReq <= r;
    @(posedge ref_clk);
    r = '{wr: 1'b0, rd: 1'b0, addr: a, data: ~d};
    if (dbg) dbgReq <= r;
    else cpuReq <= r;
    #1 q = dbg ? dbgRdData : cpuRdData;
  endtask : access
endmodule : rcso_host_model

/* File: rcso_sys_ctrl_tb.sv */
`timescale 1ns/1ns
module rcso_sys_ctrl_tb;
  import rcso_pkg::*;
  localparam logic [31:0] SHORT_CYC = 32'h10;
  localparam logic [31:0] LONG_CYC = 32'h40;
  logic ref_clk = 0;
  logic rst_n = 0;
  logic porDetect = 1;
  logic resetPin_n = 1;
  logic lowSupply = 0;
  logic wdogTimeout = 0;
  logic stopExec = 0;
  logic clkGenResetReq = 0;
  logic bgndExec = 0;
  logic [7:0] q;
  logic [7:0] cpuRdData;
  logic [7:0] dbgRdData;
  logic sysResetReq;
  rcso_req_t cpuReq;
  rcso_req_t dbgReq;
  rcso_wdog_t wdogCtrl;
  int bad_count = 0;
  int total_checks = 0;
  // 4 ns period
  always #2 ref_clk = ~ref_clk;
  rcso_host_model host (.ref_clk(ref_clk), .cpuReq(cpuReq), .dbgReq(dbgReq), .cpuRdData(cpuRdData),
    .dbgRdData(dbgRdData));
  // stop, debug-mode and stop-enable levels are held fixed to save length
  rcso_sys_ctrl #(.WDOG_SHORT_CYC(SHORT_CYC), .WDOG_LONG_CYC(LONG_CYC)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .cpuReq(cpuReq), .dbgReq(dbgReq), .porDetect(porDetect), .resetPin_n(resetPin_n), .lowSupply(lowSupply),
    .brownoutResetEnable(1'b1), .brownoutStopEnable(1'b1), .stopModeActive(1'b0), .wdogTimeout(wdogTimeout),
    .stopExec(stopExec), .bgndExec(bgndExec), .debugModeEnable(1'b0), .clkGenResetReq(clkGenResetReq),
    .cpuRdData(cpuRdData), .dbgRdData(dbgRdData), .wdogCtrl(wdogCtrl), .sysResetReq(sysResetReq));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    host.access(1'b0, 1'b0, a, 8'h00, q);
    chk("read data", q, e);
  endtask : rd
  // causes held through the whole reset; 8 edges lets the input syncs settle
  task automatic do_reset(input logic por, input logic pin, input logic low);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    porDetect <= por;
    resetPin_n <= ~pin;
    lowSupply <= low;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    porDetect <= 1'b0;
    resetPin_n <= 1'b1;
    lowSupply <= 1'b0;
    @(posedge ref_clk);
  endtask : do_reset
  task automatic wait_req();
    for (int i = 0; i < 8 && sysResetReq !== 1'b1; i++) @(posedge ref_clk) #1;
    chk("sysResetReq", sysResetReq, 1'b1);
  endtask : wait_req
  task automatic t_por();
    rd(`RCSO_ADDR_STATUS, `RCSO_CAUSE_POR);
    rd(`RCSO_ADDR_OPTIONS, 8'hC0);
    rd(`RCSO_ADDR_FORCE, `RCSO_FORCE_READ);
    chk("limit", wdogCtrl.limit, LONG_CYC);
    chk("longSel", wdogCtrl.longSel, 1'b1);
    chk("enable", wdogCtrl.enable, 1'b1);
    $display("test power-on done");
  endtask : t_por
  task automatic t_once();
    host.access(1'b0, 1'b1, `RCSO_ADDR_OPTIONS, 8'h3C, q);
    rd(`RCSO_ADDR_OPTIONS, 8'h20);
    host.access(1'b0, 1'b1, `RCSO_ADDR_OPTIONS, 8'hFF, q);
    rd(`RCSO_ADDR_OPTIONS, 8'h20);
    chk("limit", wdogCtrl.limit, SHORT_CYC);
    chk("enable", wdogCtrl.enable, 1'b0);
    chk("longSel", wdogCtrl.longSel, 1'b0);
    @(posedge ref_clk);
    wdogTimeout <= 1'b1;
    repeat (6) @(posedge ref_clk);
    wdogTimeout <= 1'b0;
    chk("sysResetReq", sysResetReq, 1'b0);
    $display("test write-once done");
  endtask : t_once
  task automatic t_kick();
    do_reset(1'b0, 1'b1, 1'b0);
    rd(`RCSO_ADDR_STATUS, 8'h40);
    host.access(1'b1, 1'b0, `RCSO_ADDR_STATUS, 8'h00, q);
    chk("debug status", q, 8'h40);
    host.access(1'b1, 1'b0, `RCSO_ADDR_FORCE, 8'h00, q);
    chk("debug force", q, `RCSO_FORCE_READ);
    host.access(1'b0, 1'b1, `RCSO_ADDR_STATUS, 8'h55, q);
    chk("restart", wdogCtrl.restart, 1'b1);
    rd(`RCSO_ADDR_STATUS, 8'h40);
    $display("test status write done");
  endtask : t_kick
  task automatic t_force();
    host.access(1'b0, 1'b1, `RCSO_ADDR_FORCE, 8'h01, q);
    repeat (4) @(posedge ref_clk);
    chk("sysResetReq", sysResetReq, 1'b0);
    host.access(1'b1, 1'b1, `RCSO_ADDR_FORCE, 8'h01, q);
    wait_req();
    do_reset(1'b0, 1'b0, 1'b0);
    rd(`RCSO_ADDR_STATUS, 8'h00);
    $display("test debug force done");
  endtask : t_force
  // k selects watchdog, illegal stop, clock generator request or illegal background
  task automatic t_cause(input int k, input logic [7:0] e);
    @(posedge ref_clk);
    wdogTimeout <= (k == 0);
    stopExec <= (k == 1);
    clkGenResetReq <= (k == 2);
    bgndExec <= (k == 3);
    @(posedge ref_clk);
    wdogTimeout <= 1'b0;
    stopExec <= 1'b0;
    clkGenResetReq <= 1'b0;
    bgndExec <= 1'b0;
    wait_req();
    do_reset(1'b0, 1'b0, 1'b0);
    rd(`RCSO_ADDR_STATUS, e);
    $display("test cause %0d done", k);
  endtask : t_cause
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #40000;
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    do_reset(1'b1, 1'b0, 1'b0);
    t_por();
    t_once();
    t_kick();
    t_force();
    t_cause(0, 8'h20);
    t_cause(1, 8'h10);
    t_cause(2, 8'h04);
    t_cause(3, 8'h10);
    do_reset(1'b0, 1'b0, 1'b1);
    rd(`RCSO_ADDR_STATUS, `RCSO_CAUSE_BROWN);
    tally_and_finish();
  end
endmodule : rcso_sys_ctrl_tb
